// ---- rtl/can_irq_map.vh ----
// Purpose: Offsets, fields, reset values and counts of the CAN interrupt and sleep control.
// Assumes: APB byte addresses, one 32-bit word per register, data in the low bits.
// Notes: Included by bare name; definitions only.
`ifndef CAN_IRQ_MAP_VH
`define CAN_IRQ_MAP_VH
`define OFS_CTRL0 8'h00
`define OFS_CFG_FIRST 6'h01
`define OFS_CFG_LAST 6'h0c
`define CFG_COUNT 12
`define OFS_RX_FLAGS 8'h34
`define OFS_RX_IRQ_EN 8'h38
`define OFS_TX_FLAGS 8'h3c
`define OFS_TX_IRQ_EN 8'h40
`define OFS_RX_ERR 8'h44
`define OFS_TX_ERR 8'h48
`define C0_SOFT_RESET 0
`define C0_SLEEP_REQ 1
`define C0_SLEEP_ACK 2
`define RF_WAKEUP 7
`define RF_RX_WARN 6
`define RF_TX_WARN 5
`define RF_RX_PASSIVE 4
`define RF_TX_PASSIVE 3
`define RF_BUS_OFF 2
`define RF_OVERRUN 1
`define RF_RX_FULL 0
`define RST_SOFT_RESET 1'h1
`define RST_CFG 8'h00
`define RST_IRQ_EN 8'h00
`define RST_TX_IRQ_EN 3'h0
`define RST_ABORT_HOLD 3'h0
`define RST_TX_EMPTY 1'h1
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h07f
`define BUS_OFF_LIMIT 9'h0ff
`define RESYNC_BITS 4'hb
`endif

// ---- rtl/sticky_flag.v ----
// Purpose: One status flag that hardware sets and software clears by writing one.
// Assumes: All inputs except presetn are synchronous to pclk; presetn resets the flag asynchronously.
// Notes: Set and hold both win over a clear in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module sticky_flag #(
   parameter RESET_VAL = 1'b0
) (
   input wire pclk,
   input wire presetn,
   input wire set_evt,
   input wire hold_cond,
   input wire clear_req,
   output reg flag_q
);
   reg flag_d;

   always @* begin
      flag_d = flag_q;
      if (clear_req) begin
         flag_d = 1'b0;
      end
      if (set_evt || hold_cond) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/sleep_ctrl.v ----
// Purpose: Sleep request handshake, wake-up and bus resynchronisation sequencing.
// Assumes: rx_level is already synchronised; bit_tick is a one-cycle bit-time enable.
// Notes: After reset the block also resynchronises before joining the bus.
`timescale 1ns/1ns
`default_nettype none
`include "can_irq_map.vh"
module sleep_ctrl (
   input wire pclk,
   input wire presetn,
   input wire sleep_req,
   input wire soft_reset,
   input wire rx_level,
   input wire bit_tick,
   input wire rx_busy,
   input wire tx_busy,
   input wire tx_pending,
   output reg sleep_ack_q,
   output reg resync_q,
   output reg bus_wake_q
);
   localparam ST_RUN = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_SLEEP = 2'h2;
   localparam ST_SYNC = 2'h3;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg drain_tx_q;
   reg [3:0] bits_q;
   reg [3:0] bits_d;
   reg wake_d;

   always @* begin
      state_d = state_q;
      bits_d = bits_q;
      wake_d = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (sleep_req && !soft_reset) begin
               state_d = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!sleep_req || soft_reset) begin
               state_d = ST_RUN;
            end else if (!rx_busy && !tx_busy && !(drain_tx_q && tx_pending)) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (soft_reset || !sleep_req) begin
               state_d = ST_SYNC;
            end else if (!rx_level) begin
               state_d = ST_SYNC;
               wake_d = 1'b1;
            end
            bits_d = 4'h0;
         end
         ST_SYNC: begin
            if (bit_tick) begin
               if (!rx_level) begin
                  bits_d = 4'h0;
               end else if (bits_q == `RESYNC_BITS - 4'h1) begin
                  bits_d = 4'h0;
                  state_d = ST_RUN;
               end else begin
                  bits_d = bits_q + 4'h1;
               end
            end
         end
         default: begin
            state_d = ST_SYNC;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_SYNC;
         bits_q <= 4'h0;
         drain_tx_q <= 1'b0;
         sleep_ack_q <= 1'b0;
         resync_q <= 1'b1;
         bus_wake_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bits_q <= bits_d;
         drain_tx_q <= (state_q == ST_DRAIN) && (drain_tx_q || tx_busy);
         sleep_ack_q <= (state_d == ST_SLEEP);
         resync_q <= (state_d == ST_SYNC);
         bus_wake_q <= wake_d;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/can_irq_and_sleep_control.v ----
// Purpose: Interrupt flags, configuration lock and low-power control of a CAN controller.
// Assumes: Protocol engine inputs are synchronous to pclk; rx_pin is asynchronous.
// Notes: APB slave answers every access in its first access cycle.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "can_irq_map.vh"
module can_irq_and_sleep_control (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire cpu_stop,
   input wire rx_pin,
   input wire tx_bit,
   input wire bit_tick,
   input wire rx_busy,
   input wire tx_busy,
   input wire rx_accept,
   input wire [2:0] tx_done,
   input wire [2:0] abort_done,
   input wire [7:0] rx_err_cnt,
   input wire [8:0] tx_err_cnt,
   output reg tx_pin,
   output reg irq_wakeup,
   output reg irq_error,
   output reg irq_receive,
   output reg irq_transmit,
   output reg core_clk_en,
   output reg reg_clk_en,
   output reg bus_join,
   output reg rx_copy,
   output reg recovery_count_en,
   output wire [2:0] tx_empty,
   output wire [95:0] cfg_bus,
   output wire soft_reset_bit,
   output wire sleep_acknowledge
);
   reg rx_meta_q;
   reg rx_sync_q;
   reg sleep_request;
   reg soft_reset_q;
   reg [7:0] rx_irq_en_q;
   reg [2:0] tx_irq_en_q;
   reg bg_full_q;
   reg bg_full_d;
   reg [7:0] cfg_q [0:`CFG_COUNT-1];
   wire [10:0] flags_q;
   reg [10:0] flag_set;
   reg [10:0] flag_hold;
   wire [10:0] flag_clr;
   wire sleep_ack;
   wire resync;
   wire bus_wake;
   wire setup_cyc;
   wire wr_en;
   wire cfg_hit;
   wire [5:0] word_idx;
   wire [5:0] cfg_idx;
   wire join_now;
   wire copy_go;
   wire overrun_evt;
   wire tx_pending;
   reg [8:0] rd_data;
   reg rd_hit;
   reg [2:0] abort_hold_q;
   reg [2:0] abort_hold_d;
   wire [2:0] abort_apply;
   wire run_mode;
   wire access_err;

   assign setup_cyc = psel && !penable;
   // Power down blocks every register write; reads also answer with an error then.
   assign wr_en = psel && penable && pready && pwrite && !cpu_stop;
   assign word_idx = paddr[7:2];
   assign cfg_hit = (paddr[1:0] == 2'h0) && (word_idx >= `OFS_CFG_FIRST) &&
      (word_idx <= `OFS_CFG_LAST);
   assign cfg_idx = word_idx - `OFS_CFG_FIRST;
   assign tx_empty = flags_q[10:8];
   assign tx_pending = ~&flags_q[10:8];
   assign soft_reset_bit = soft_reset_q;
   assign sleep_acknowledge = sleep_ack;

   // Two flip-flops before the bus level is looked at.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   sleep_ctrl u_sleep (
      .pclk(pclk),
      .presetn(presetn),
      .sleep_req(sleep_request),
      .soft_reset(soft_reset_q),
      .rx_level(rx_sync_q),
      .bit_tick(bit_tick),
      .rx_busy(rx_busy),
      .tx_busy(tx_busy),
      .tx_pending(tx_pending),
      .sleep_ack_q(sleep_ack),
      .resync_q(resync),
      .bus_wake_q(bus_wake)
   );

   // mode from stop and bits
   // Normal mode only while the CPU runs, with no sleep acknowledge and soft reset clear.
   assign run_mode = !cpu_stop && !sleep_ack && !soft_reset_q;
   // Rejoining also waits for the resynchronisation after wake-up or reset.
   assign join_now = run_mode && !resync;

   // Control register 0: soft reset and the sleep request handshake.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_reset_q <= `RST_SOFT_RESET;
         sleep_request <= 1'b0;
      end else begin
         if (wr_en && (paddr == `OFS_CTRL0)) begin
            soft_reset_q <= pwdata[`C0_SOFT_RESET];
            if (pwdata[`C0_SLEEP_REQ]) begin
               sleep_request <= 1'b1;
            end else if (sleep_ack) begin
               sleep_request <= 1'b0;
            end
         end else if (bus_wake) begin
            // Bus wake-up withdraws the request so the node does not fall asleep again.
            sleep_request <= 1'b0;
         end
      end
   end

   // Interrupt enable registers are writable in every mode except power down.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_irq_en_q <= `RST_IRQ_EN;
         tx_irq_en_q <= `RST_TX_IRQ_EN;
      end else begin
         if (wr_en && (paddr == `OFS_RX_IRQ_EN)) begin
            rx_irq_en_q <= pwdata[7:0];
         end
         if (wr_en && (paddr == `OFS_TX_IRQ_EN)) begin
            tx_irq_en_q <= pwdata[2:0];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `CFG_COUNT; gi = gi + 1) begin : g_cfg
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg_q[gi] <= `RST_CFG;
            end else if (wr_en && cfg_hit && soft_reset_q && (cfg_idx == gi)) begin
               cfg_q[gi] <= pwdata[7:0];
            end
         end
         assign cfg_bus[8*gi+7:8*gi] = cfg_q[gi];
      end
   endgenerate

   // Receive buffer bookkeeping: background slot plus the foreground full flag.
   // no copy while asleep
   assign copy_go = join_now && !flags_q[`RF_RX_FULL] && (bg_full_q || rx_accept);
   assign overrun_evt = join_now && rx_accept && bg_full_q && flags_q[`RF_RX_FULL];

   always @* begin
      bg_full_d = bg_full_q;
      if (copy_go) begin
         bg_full_d = bg_full_q && rx_accept;
      end else if (rx_accept && join_now) begin
         bg_full_d = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bg_full_q <= 1'b0;
      end else begin
         bg_full_q <= bg_full_d;
      end
   end

   // aborts wait for rejoin
   // The engine is stopped in sleep, yet a stray abort must not free a buffer before rejoin.
   always @* begin
      abort_hold_d = abort_hold_q | abort_done;
      if (join_now) begin
         abort_hold_d = 3'h0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_hold_q <= `RST_ABORT_HOLD;
      end else begin
         abort_hold_q <= abort_hold_d;
      end
   end

   assign abort_apply = join_now ? (abort_hold_q | abort_done) : 3'h0;

   always @* begin
      flag_set = 11'h000;
      flag_hold = 11'h000;
      flag_set[`RF_WAKEUP] = sleep_ack && rx_irq_en_q[`RF_WAKEUP] && !rx_sync_q;
      flag_hold[`RF_RX_WARN] = ({1'b0, rx_err_cnt} >= `WARN_LIMIT);
      flag_hold[`RF_TX_WARN] = (tx_err_cnt >= `WARN_LIMIT);
      flag_hold[`RF_RX_PASSIVE] = ({1'b0, rx_err_cnt} > `PASSIVE_LIMIT);
      flag_hold[`RF_TX_PASSIVE] = (tx_err_cnt > `PASSIVE_LIMIT);
      flag_hold[`RF_BUS_OFF] = (tx_err_cnt > `BUS_OFF_LIMIT);
      flag_set[`RF_OVERRUN] = overrun_evt;
      flag_set[`RF_RX_FULL] = copy_go;
      flag_set[10:8] = tx_done | abort_apply;
   end

   assign flag_clr[7:0] = {8{wr_en && (paddr == `OFS_RX_FLAGS)}} & pwdata[7:0];
   assign flag_clr[10:8] = {3{wr_en && (paddr == `OFS_TX_FLAGS)}} & pwdata[2:0];

   generate
      for (gi = 0; gi < 11; gi = gi + 1) begin : g_flag
         sticky_flag #(
            .RESET_VAL((gi >= 8) ? `RST_TX_EMPTY : 1'b0)
         ) u_flag (
            .pclk(pclk),
            .presetn(presetn),
            .set_evt(flag_set[gi]),
            .hold_cond(flag_hold[gi]),
            .clear_req(flag_clr[gi]),
            .flag_q(flags_q[gi])
         );
      end
   endgenerate

   // Read multiplexer; error counters appear here only, with no write path.
   always @* begin
      rd_data = 9'h000;
      rd_hit = 1'b1;
      if (cfg_hit) begin
         rd_data = {1'b0, cfg_q[cfg_idx[3:0]]};
      end else begin
         case (paddr)
            `OFS_CTRL0: begin
               rd_data = {6'h00, sleep_ack, sleep_request, soft_reset_q};
            end
            `OFS_RX_FLAGS: begin
               rd_data = {1'b0, flags_q[7:0]};
            end
            `OFS_RX_IRQ_EN: begin
               rd_data = {1'b0, rx_irq_en_q};
            end
            `OFS_TX_FLAGS: begin
               rd_data = {6'h00, flags_q[10:8]};
            end
            `OFS_TX_IRQ_EN: begin
               rd_data = {6'h00, tx_irq_en_q};
            end
            `OFS_RX_ERR: begin
               rd_data = {1'b0, rx_err_cnt};
            end
            `OFS_TX_ERR: begin
               rd_data = tx_err_cnt;
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
      end
   end

   // Power down and unmapped addresses answer with an error and zero data.
   assign access_err = !rd_hit || cpu_stop;

   // The answer is prepared in the setup cycle so that pready can come from a flip-flop.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_cyc;
         pslverr <= setup_cyc && access_err;
         if (setup_cyc && !pwrite) begin
            prdata <= access_err ? 32'h00000000 : {23'h000000, rd_data};
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_wakeup <= 1'b0;
         irq_error <= 1'b0;
         irq_receive <= 1'b0;
         irq_transmit <= 1'b0;
      end else begin
         irq_wakeup <= flags_q[`RF_WAKEUP] && rx_irq_en_q[`RF_WAKEUP];
         irq_error <= |(flags_q[6:1] & rx_irq_en_q[6:1]);
         irq_receive <= flags_q[`RF_RX_FULL] && rx_irq_en_q[`RF_RX_FULL];
         irq_transmit <= |(flags_q[10:8] & tx_irq_en_q);
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pin <= 1'b1;
         core_clk_en <= 1'b0;
         reg_clk_en <= 1'b0;
         bus_join <= 1'b0;
         rx_copy <= 1'b0;
         recovery_count_en <= 1'b0;
      end else begin
         tx_pin <= run_mode ? tx_bit : 1'b1;
         core_clk_en <= run_mode;
         reg_clk_en <= !cpu_stop;
         bus_join <= join_now;
         rx_copy <= copy_go;
         recovery_count_en <= flags_q[`RF_BUS_OFF] && run_mode;
      end
   end
endmodule
`default_nettype wire

// ---- verif/can_irq_properties.sv ----
// Purpose: Port-level properties of the CAN interrupt and sleep control.
// Assumes: One pclk domain; presetn is asynchronous and active low.
// Notes: Receive flags are internal, so their effect is judged at irq and mode outputs; tx_empty is seen directly.
`timescale 1ns/1ns
`default_nettype none
module can_irq_properties (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire cpu_stop,
   input wire tx_pin,
   input wire irq_transmit,
   input wire core_clk_en,
   input wire reg_clk_en,
   input wire bus_join,
   input wire rx_copy,
   input wire [2:0] tx_empty,
   input wire soft_reset_bit,
   input wire sleep_acknowledge
);
   wire low_power;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A mode is only trusted after it has held for a cycle, since tx_pin is registered.
   assign low_power = soft_reset_bit || sleep_acknowledge || cpu_stop;
   a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   a_access_refused: assert property (psel && !penable && (paddr > 8'h48 || cpu_stop) |=> pslverr)
      else $error("refused access without pslverr");
   a_stop_clocks_off: assert property (cpu_stop |=> !reg_clk_en && !core_clk_en)
      else $error("clocks running in power down");
   a_soft_core_off: assert property (soft_reset_bit |=> !core_clk_en && !bus_join)
      else $error("core active in soft reset");
   a_sleep_core_off: assert property (sleep_acknowledge |=> !core_clk_en)
      else $error("core clock running in sleep");
   a_pin_recessive: assert property (low_power ##1 low_power |-> tx_pin)
      else $error("tx_pin dominant in low power");
   a_no_sleep_copy: assert property (sleep_acknowledge && $past(sleep_acknowledge) |-> !rx_copy)
      else $error("buffer copy during sleep");
   a_tx_irq_flag: assert property (tx_empty == 3'b000 |=> !irq_transmit)
      else $error("transmit irq with no empty flag");
   a_join_normal: assert property ($rose(bus_join) |-> core_clk_en && !sleep_acknowledge)
      else $error("bus joined outside normal mode");
   c_sleep: cover property ($rose(sleep_acknowledge));
   c_copy: cover property (rx_copy);
   c_join: cover property ($rose(bus_join));
   c_stop: cover property (cpu_stop ##1 !reg_clk_en);
endmodule
`default_nettype wire

// ---- verif/can_bus_node.sv ----
// Purpose: Other nodes on the CAN bus, seen as the bus level and the bit clock.
// Assumes: Idle bus is recessive, as the bus termination pulls it there.
// Notes: Levels change only at bit boundaries, so a request lasts at least a bit.
`timescale 1ns/1ns
`default_nettype none
module can_bus_node (
   input wire pclk,
   input wire presetn,
   input wire dominant,
   output logic rx_pin,
   output logic bit_tick
);
   logic [2:0] div_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 3'h0;
         bit_tick <= 1'b0;
         rx_pin <= 1'b1;
      end else begin
         div_q <= div_q + 3'h1;
         bit_tick <= (div_q == 3'h7);
         if (div_q == 3'h7) rx_pin <= !dominant;
      end
   end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Register-level test of the CAN interrupt and sleep control.
// Assumes: APB answers within twenty cycles; bus node ticks every eight cycles.
// Notes: Engine inputs are driven directly in place of the protocol engine.
`timescale 1ns/1ns
`default_nettype none
`include "can_irq_map.vh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin num_errors++; \
   $display("Error %s expected %h seen %h", n, e, v); end end
module testbench;
   logic pclk, presetn, psel, penable, pwrite, cpu_stop, rx_busy, tx_busy, rx_accept, dominant;
   logic [7:0] paddr, rx_err_cnt;
   logic [31:0] pwdata, prdata, rdata;
   logic pready, pslverr, rerr, tx_bit, rx_pin, bit_tick, tx_pin, irq_wakeup, irq_error;
   logic irq_receive, irq_transmit, core_clk_en, reg_clk_en, bus_join, rx_copy;
   logic soft_reset_bit, sleep_acknowledge, recovery_count_en;
   logic [2:0] tx_done, abort_done, tx_empty;
   logic [8:0] tx_err_cnt;
   logic [95:0] cfg_bus;
   int num_errors = 0;
   int comparisons = 0;
   int i;
   logic [7:0] rc [0:2] = '{8'h5f, 8'h7f, 8'h80};
   logic [8:0] tc [0:2] = '{9'h05f, 9'h0ff, 9'h100};
   logic [31:0] ef [0:2] = '{32'h0, 32'h68, 32'h7c};
   localparam logic [7:0] CF = {`OFS_CFG_FIRST, 2'b00};
   localparam logic [7:0] CL = {`OFS_CFG_LAST, 2'b00};
   can_irq_and_sleep_control can_irq_and_sleep_control_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stop(cpu_stop),
      .rx_pin(rx_pin), .tx_bit(tx_bit), .bit_tick(bit_tick), .rx_busy(rx_busy),
      .tx_busy(tx_busy), .rx_accept(rx_accept), .tx_done(tx_done), .abort_done(abort_done),
      .rx_err_cnt(rx_err_cnt), .tx_err_cnt(tx_err_cnt), .tx_pin(tx_pin),
      .irq_wakeup(irq_wakeup), .irq_error(irq_error), .irq_receive(irq_receive),
      .irq_transmit(irq_transmit), .core_clk_en(core_clk_en), .reg_clk_en(reg_clk_en),
      .bus_join(bus_join), .rx_copy(rx_copy), .recovery_count_en(recovery_count_en),
      .tx_empty(tx_empty), .cfg_bus(cfg_bus), .soft_reset_bit(soft_reset_bit),
      .sleep_acknowledge(sleep_acknowledge));
   can_bus_node can_bus_node_i (.pclk(pclk), .presetn(presetn), .dominant(dominant),
      .rx_pin(rx_pin), .bit_tick(bit_tick));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task stop_test;
      if (num_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 20);
         rdata = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n >= 20) begin
            num_errors++;
            stop_test();
         end
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rdata);
   endtask
   task wait_sig(input int s, input logic v);
      int n;
      begin
         n = 0;
         while (((s == 0) ? sleep_acknowledge : bus_join) !== v && n < 2000) begin
            @(posedge pclk);
            n++;
         end
         if (n >= 2000) begin
            num_errors++;
            stop_test();
         end
      end
   endtask
   task pulse_rx;
      rx_accept <= 1'b1;
      @(posedge pclk);
      rx_accept <= 1'b0;
      @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, cpu_stop, rx_busy, tx_busy, rx_accept, dominant} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx_bit = 1'b1;
      tx_done = 3'h0;
      abort_done = 3'h0;
      rx_err_cnt = 8'h00;
      tx_err_cnt = 9'h000;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_CTRL0, 32'h1, "ctrl0");
      rd(`OFS_TX_FLAGS, 32'h7, "tx_flags");
      `CHK("tx_pin", 1'b1, tx_pin);
      apb(1'b1, CF, 32'ha5);
      apb(1'b1, CL, 32'hc3);
      apb(1'b1, `OFS_CTRL0, 32'h0);
      apb(1'b1, CF, 32'h5a);
      apb(1'b1, CL, 32'h5a);
      rd(CF, 32'ha5, "cfg_first");
      rd(CL, 32'hc3, "cfg_last");
      `CHK("cfg_bus", 8'hc3, cfg_bus[95:88]);
      rx_err_cnt <= 8'h10;
      apb(1'b1, `OFS_RX_ERR, 32'hff);
      rd(`OFS_RX_ERR, 32'h10, "rx_err");
      apb(1'b1, `OFS_RX_IRQ_EN, 32'hff);
      for (i = 0; i < 3; i++) begin
         rx_err_cnt <= rc[i];
         tx_err_cnt <= tc[i];
         rd(`OFS_RX_FLAGS, ef[i], "err_flags");
      end
      `CHK("irq_error", 1'b1, irq_error);
      `CHK("recovery_run", 1'b1, recovery_count_en);
      apb(1'b1, `OFS_RX_FLAGS, 32'hff);
      rd(`OFS_RX_FLAGS, 32'h7c, "flags_held");
      rx_err_cnt <= 8'h00;
      tx_err_cnt <= 9'h000;
      apb(1'b1, `OFS_RX_FLAGS, 32'h0);
      rd(`OFS_RX_FLAGS, 32'h7c, "flags_zero");
      apb(1'b1, `OFS_RX_FLAGS, 32'h7c);
      rd(`OFS_RX_FLAGS, 32'h0, "flags_clr");
      `CHK("irq_error", 1'b0, irq_error);
      wait_sig(1, 1'b1);
      pulse_rx();
      `CHK("rx_copy", 1'b1, rx_copy);
      rd(`OFS_RX_FLAGS, 32'h1, "rx_full");
      `CHK("irq_receive", 1'b1, irq_receive);
      pulse_rx();
      pulse_rx();
      rd(`OFS_RX_FLAGS, 32'h3, "overrun");
      `CHK("irq_error", 1'b1, irq_error);
      apb(1'b1, `OFS_RX_FLAGS, 32'h2);
      rd(`OFS_RX_FLAGS, 32'h1, "ovr_clr");
      apb(1'b1, `OFS_TX_IRQ_EN, 32'h7);
      apb(1'b1, `OFS_TX_FLAGS, 32'h3);
      rd(`OFS_TX_FLAGS, 32'h4, "tx_one");
      `CHK("irq_transmit", 1'b1, irq_transmit);
      apb(1'b1, `OFS_TX_FLAGS, 32'h4);
      rd(`OFS_TX_FLAGS, 32'h0, "tx_none");
      `CHK("irq_transmit", 1'b0, irq_transmit);
      tx_done <= 3'h2;
      @(posedge pclk);
      tx_done <= 3'h0;
      abort_done <= 3'h5;
      @(posedge pclk);
      abort_done <= 3'h0;
      rd(`OFS_TX_FLAGS, 32'h7, "tx_set");
      tx_busy <= 1'b1;
      apb(1'b1, `OFS_CTRL0, 32'h2);
      repeat (20) @(posedge pclk);
      `CHK("sleep_ack", 1'b0, sleep_acknowledge);
      apb(1'b1, `OFS_CTRL0, 32'h0);
      rd(`OFS_CTRL0, 32'h2, "early_clr");
      tx_busy <= 1'b0;
      wait_sig(0, 1'b1);
      rd(`OFS_CTRL0, 32'h6, "asleep");
      `CHK("core_clk_en", 1'b0, core_clk_en);
      `CHK("reg_clk_en", 1'b1, reg_clk_en);
      apb(1'b1, `OFS_RX_FLAGS, 32'h1);
      rd(`OFS_RX_FLAGS, 32'h0, "sleep_rxf");
      apb(1'b1, `OFS_TX_FLAGS, 32'h1);
      rd(`OFS_TX_FLAGS, 32'h6, "sleep_txe");
      tx_err_cnt <= 9'h100;
      abort_done <= 3'h1;
      @(posedge pclk);
      abort_done <= 3'h0;
      repeat (2) @(posedge pclk);
      `CHK("recovery_sleep", 1'b0, recovery_count_en);
      rd(`OFS_TX_FLAGS, 32'h6, "sleep_abort");
      dominant <= 1'b1;
      wait_sig(0, 1'b0);
      dominant <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("irq_wakeup", 1'b1, irq_wakeup);
      `CHK("bus_join", 1'b0, bus_join);
      wait_sig(1, 1'b1);
      `CHK("recovery_wake", 1'b1, recovery_count_en);
      rd(`OFS_RX_FLAGS, 32'had, "wake_copy");
      rd(`OFS_TX_FLAGS, 32'h7, "wake_abort");
      tx_err_cnt <= 9'h000;
      rd(`OFS_CTRL0, 32'h0, "awake");
      cpu_stop <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("reg_clk_en", 1'b0, reg_clk_en);
      rd(`OFS_CTRL0, 32'h0, "stop_rd");
      `CHK("stop_err", 1'b1, rerr);
      cpu_stop <= 1'b0;
      rd(8'hfc, 32'h0, "unmapped");
      `CHK("unmapped_err", 1'b1, rerr);
      stop_test();
   end
endmodule
bind can_irq_and_sleep_control can_irq_properties can_irq_properties_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .cpu_stop(cpu_stop), .tx_pin(tx_pin), .irq_transmit(irq_transmit),
   .core_clk_en(core_clk_en), .reg_clk_en(reg_clk_en), .bus_join(bus_join),
   .rx_copy(rx_copy), .tx_empty(tx_empty), .soft_reset_bit(soft_reset_bit),
   .sleep_acknowledge(sleep_acknowledge));
`default_nettype wire
